// *** rtl/ceebr_pkg.sv ***
// Package for the CAN error-event and bus-off recovery block
package ceebr_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_GLOBAL_CONTROL_REG = 8'h00; // global_control_reg
	localparam logic [7:0] OFS_GFLG  = 8'h04; // global error flags
	localparam logic [7:0] OFS_CCTLL = 8'h08; // channel_control_low_reg
	localparam logic [7:0] OFS_CCTLH = 8'h0c; // channel_control_high_reg
	localparam logic [7:0] OFS_CFLG  = 8'h10; // channel_error_flags_reg
	localparam logic [7:0] OFS_CSTS  = 8'h14; // channel status
	localparam logic [7:0] OFS_TXF   = 8'h18; // transmit abort flag

	// ==========================================================
	// Field positions
	localparam int GR_BIT     = 0;  // global reset mode
	localparam int DLCEN_BIT  = 1;  // DLC check enable
	localparam int GIE_LSB    = 8;  // four global irq enables
	localparam int MODE_LSB   = 0;  // channel_mode_request
	localparam int FEXIT_BIT  = 2;  // forced_busoff_exit
	localparam int CIE_LSB    = 8;  // eleven channel error enables
	localparam int TAIE_BIT   = 19; // transmit abort enable
	localparam int POL_LSB    = 0;  // busoff_recovery_policy
	localparam int DET_LSB    = 16; // bus error detail flags
	localparam int ECNT_LSB   = 8;
	localparam int SCNT_LSB   = 16;

	// Global flag indexes
	localparam int G_DLC  = 0;
	localparam int G_LOST = 1;
	localparam int G_HIST = 2;
	localparam int G_POV  = 3;

	// Channel event flag indexes
	localparam int EV_BERR = 0;
	localparam int EV_WARN = 1;
	localparam int EV_PASS = 2;
	localparam int EV_BOE  = 3;
	localparam int EV_BOR  = 4;
	localparam int EV_OVL  = 5;
	localparam int EV_LOCK = 6;
	localparam int EV_ARB  = 7;
	localparam int EV_EOCO = 8;
	localparam int EV_SOCO = 9;
	localparam int EV_TDCV = 10;

	// ==========================================================
	// Encodings, limits and counts
	localparam logic [1:0] CHM_OP    = 2'h0;
	localparam logic [1:0] CHM_RESET = 2'h1;
	localparam logic [1:0] CHM_HALT  = 2'h2;
	localparam logic [1:0] POL_STD   = 2'h0;
	localparam logic [1:0] POL_ENTRY = 2'h1;
	localparam logic [1:0] POL_END   = 2'h2;
	localparam logic [1:0] POL_PROG  = 2'h3;
	localparam logic [8:0] WARN_LIM  = 9'h05f; // 95
	localparam logic [8:0] PASS_LIM  = 9'h07f; // 127
	localparam logic [8:0] BO_LIM    = 9'h0ff; // 255
	localparam logic [3:0] RUN_LAST  = 4'ha;   // 11th recessive bit
	localparam logic [6:0] RCNT_LAST = 7'h7f;  // 128th run
	localparam logic [5:0] LOCK_LAST = 6'h1f;  // 32nd dominant bit
	localparam logic [7:0] CNT_MAX   = 8'hff;
	localparam logic [10:0] TDC_SUB  = 11'h002; // two controller clocks

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		BO_ON  = 2'b01,
		BO_OFF = 2'b10
	} ceebr_bo_e;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} ceebr_wb_req_s;

	typedef struct packed {
		logic       rx_done;        // accepted frame, one pulse
		logic [3:0] rx_dlc;
		logic [3:0] rule_min_dlc;
		logic [6:0] rx_len;         // payload bytes
		logic [6:0] buf_size;       // destination payload bytes
		logic       fifo_full_store;
		logic       hist_full_store;
		logic [5:0] err_detail;     // stuff,ack,crc,bit1,bit0,ackdelim
		logic       overload;
		logic       arb_lost;
		logic       err_cnt_match;  // bus error under counting condition
		logic       frame_ok;
		logic       bit_strobe;
		logic       rx_bit;         // 1 = recessive
		logic [7:0] rec;
		logic [8:0] tx_error_counter;
		logic       tdc_valid;
		logic [7:0] tdc_meas;       // controller clocks
		logic [7:0] dbt_clks;       // controller clocks per data bit
		logic       abort_done;
		logic       tx_done_req;
		logic       cf_tx_req;
		logic       hist_req;
	} ceebr_core_s;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdat;
		logic        glob_rst;
		logic        dlc_en;
		logic [3:0]  gie;
		logic [3:0]  gflg;
		logic [1:0]  mode;
		logic [10:0] cie;
		logic        taie;
		logic [1:0]  pol;
		logic [10:0] cflg;
		logic [5:0]  eflg;
		logic        abort_flg;
		ceebr_bo_e   bo;
		logic        pend_halt;
		logic        supp;
		logic [3:0]  run;
		logic [6:0]  rcnt;
		logic [5:0]  dom;
		logic        warn_l;
		logic        pas_l;
		logic        tec_ov;
		logic [7:0]  ecnt;
		logic [7:0]  scnt;
		logic        girq;
		logic        cirq;
		logic        tirq;
	} ceebr_st_s;

endpackage

// *** rtl/ceebr_top.sv ***
// Error events and bus-off recovery for one CAN channel
//
// Overview of operation
// - Short DLC against rule minimum flags error
// - Store into full FIFO flags message lost
// - Store into full history flags entry lost
// - Payload above buffer size flags overflow
// - Overflow suppressed when DLC error raised
// - Any bus error sets flag and event
// - Warning event once when counter exceeds 95
// - Passive event once when counter exceeds 127
// - Bus-off entry event when TX_ERROR_COUNTER exceeds 255
// - Recovery after 128 runs of 11 recessive
// - Separate overload and arbitration lost events
// - Bus lock on 32 dominant in operation
// - Error counter overflow at H'FF on error
// - Success counter overflow at H'FF on frame
// - Delay compensation violation above limit
// - Abort event merged into transmit interrupt
// - Two-bit policy selects recovery behaviour
// - Reset or policy-3 halt cancels recovery event
// - Standard policy defers halt; forced exit silent
// - Program mode write beats automatic halt
// - Automatic halt only in operation mode
//
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module ceebr_top (
	input  wire logic                   CLK_IN,
	input  wire logic                   ARST_N_IN,
	input  wire ceebr_pkg::ceebr_wb_req_s WB_REQ_IN,
	output logic                        WB_ACK_OUT,
	output logic [31:0]                 WB_DAT_OUT,
	input  wire ceebr_pkg::ceebr_core_s CORE_IN,
	output logic                        GERR_IRQ_OUT,
	output logic                        CHERR_IRQ_OUT,
	output logic                        CHTX_IRQ_OUT,
	output logic [1:0]                  CH_MODE_OUT,
	output logic                        BUSOFF_OUT
);
	import ceebr_pkg::*;

	ceebr_st_s s_q;
	ceebr_st_s s_d;

	logic        acc;
	logic        wr;
	logic [31:0] wm;
	logic [31:0] wd;
	logic [7:0]  adr;
	logic        mode_wr;
	logic [1:0]  new_mode;
	logic        busoff;
	logic        is_op;
	logic        dlc_err;
	logic        pov;
	logic [3:0]  gset;
	logic        berr;
	logic        warn_lvl;
	logic        pass_lvl;
	logic        tec_ov;
	logic        boe;
	logic        rec_done;
	logic        mode_rst_wr;
	logic        halt_prog;
	logic        forced;
	logic        bor;
	logic        lock_ev;
	logic        eoco;
	logic        soco;
	logic [10:0] tdc_lim;
	logic        tdcv;
	logic [10:0] cset;
	logic        auto_halt;

	// ==========================================================
	// Bus access decode
	// A request is taken once; ack blocks a second take while held
	assign acc      = WB_REQ_IN.cyc & WB_REQ_IN.stb & ~s_q.ack;
	assign wr       = acc & WB_REQ_IN.we;
	assign adr      = WB_REQ_IN.adr;
	assign wm       = {{8{WB_REQ_IN.sel[3]}}, {8{WB_REQ_IN.sel[2]}},
	                   {8{WB_REQ_IN.sel[1]}}, {8{WB_REQ_IN.sel[0]}}};
	assign wd       = WB_REQ_IN.dat & wm;
	assign mode_wr  = wr && (adr == OFS_CCTLL) && WB_REQ_IN.sel[0];
	assign new_mode = WB_REQ_IN.dat[MODE_LSB +: 2];
	assign busoff   = s_q.bo == BO_OFF;
	assign is_op    = s_q.mode == CHM_OP;

	// ==========================================================
	// Global buffer error sources
	assign dlc_err = CORE_IN.rx_done & s_q.dlc_en
	               & (CORE_IN.rx_dlc < CORE_IN.rule_min_dlc);
	// Length check goes first, so a frame flagged with a DLC error never overflows
	assign pov = CORE_IN.rx_done & ~dlc_err
	           & (CORE_IN.rx_len > CORE_IN.buf_size);
	assign gset = {pov, CORE_IN.hist_full_store,
	               CORE_IN.fifo_full_store, dlc_err};

	// ==========================================================
	// Channel error sources
	assign berr     = |CORE_IN.err_detail;
	assign warn_lvl = ({1'b0, CORE_IN.rec} > WARN_LIM)
	                | (CORE_IN.tx_error_counter > WARN_LIM);
	assign pass_lvl = ({1'b0, CORE_IN.rec} > PASS_LIM)
	                | (CORE_IN.tx_error_counter > PASS_LIM);
	assign tec_ov   = CORE_IN.tx_error_counter > BO_LIM;
	// Edge of the overflow level, so a lingering TX_ERROR_COUNTER cannot re-enter
	assign boe      = tec_ov & ~s_q.tec_ov & ~busoff;
	assign rec_done = busoff & CORE_IN.bit_strobe & CORE_IN.rx_bit
	                & (s_q.run == RUN_LAST)
	                & (s_q.rcnt == RCNT_LAST);
	assign mode_rst_wr = mode_wr & (new_mode == CHM_RESET);
	assign halt_prog   = mode_wr & (new_mode == CHM_HALT) & busoff
	                   & (s_q.pol == POL_PROG);
	assign forced      = wr && (adr == OFS_CCTLL) && WB_REQ_IN.sel[0]
	                   && WB_REQ_IN.dat[FEXIT_BIT] && busoff;
	// Policy 1 never reports recovery; cancelled recoveries stay silent
	assign bor = rec_done & ~s_q.supp & ~mode_rst_wr & ~halt_prog
	           & (s_q.pol != POL_ENTRY);
	assign lock_ev = is_op & CORE_IN.bit_strobe & ~CORE_IN.rx_bit
	               & (s_q.dom == LOCK_LAST);
	assign eoco = CORE_IN.err_cnt_match & (s_q.ecnt == CNT_MAX);
	assign soco = CORE_IN.frame_ok & (s_q.scnt == CNT_MAX);
	// Limit is six data bits less two clocks; a zero bit time wraps high
	assign tdc_lim = (11'({3'h0, CORE_IN.dbt_clks}) << 2)
	               + (11'({3'h0, CORE_IN.dbt_clks}) << 1) - TDC_SUB;
	assign tdcv = CORE_IN.tdc_valid
	            & ({3'h0, CORE_IN.tdc_meas} > tdc_lim);
	assign cset = {tdcv, soco, eoco, CORE_IN.arb_lost, lock_ev,
	               CORE_IN.overload, bor, boe,
	               pass_lvl & ~s_q.pas_l,
	               warn_lvl & ~s_q.warn_l, berr};
	// Policy-driven halts, only from operation mode
	assign auto_halt = is_op & (((s_q.pol == POL_ENTRY) & boe)
	                 | ((s_q.pol == POL_END) & rec_done));

	// ==========================================================
	// Next state
	always_comb begin
		s_d = s_q;
		s_d.ack = acc;
		s_d.tec_ov = tec_ov;
		s_d.warn_l = warn_lvl;
		s_d.pas_l = pass_lvl;

		// Set wins over a clear landing in the same cycle
		s_d.gflg = s_q.gflg | gset;
		s_d.cflg = s_q.cflg | cset;
		s_d.eflg = s_q.eflg | CORE_IN.err_detail;
		s_d.abort_flg = s_q.abort_flg
		              | (CORE_IN.abort_done & s_q.taie);
		if (wr && adr == OFS_GFLG) begin
			s_d.gflg = (s_q.gflg & ~wd[3:0]) | gset;
		end else if (wr && adr == OFS_CFLG) begin
			s_d.cflg = (s_q.cflg & ~wd[10:0]) | cset;
			s_d.eflg = (s_q.eflg & ~wd[DET_LSB +: 6]) | CORE_IN.err_detail;
		end else if (wr && adr == OFS_TXF) begin
			s_d.abort_flg = (s_q.abort_flg & ~wd[0])
			              | (CORE_IN.abort_done & s_q.taie);
		end

		// Configuration writes
		if (wr && adr == OFS_GLOBAL_CONTROL_REG) begin
			if (WB_REQ_IN.sel[0]) begin
				s_d.glob_rst = WB_REQ_IN.dat[GR_BIT];
				s_d.dlc_en = WB_REQ_IN.dat[DLCEN_BIT];
			end
			// Global interrupt enables only move in global reset mode
			if (WB_REQ_IN.sel[1] && s_q.glob_rst) begin
				s_d.gie = WB_REQ_IN.dat[GIE_LSB +: 4];
			end
		end else if (wr && adr == OFS_CCTLL) begin
			if (WB_REQ_IN.sel[1]) begin
				s_d.cie[7:0] = WB_REQ_IN.dat[CIE_LSB +: 8];
			end
			if (WB_REQ_IN.sel[2]) begin
				s_d.cie[10:8] = WB_REQ_IN.dat[CIE_LSB + 8 +: 3];
				s_d.taie = WB_REQ_IN.dat[TAIE_BIT];
			end
		end else if (wr && adr == OFS_CCTLH) begin
			if (WB_REQ_IN.sel[0]) begin
				s_d.pol = WB_REQ_IN.dat[POL_LSB +: 2];
			end
		end

		// Channel mode: program write first, then automatic halt
		if (mode_wr) begin
			if (busoff && s_q.pol == POL_STD && new_mode == CHM_HALT) begin
				s_d.pend_halt = 1'b1;
			end else begin
				s_d.mode = new_mode;
				s_d.pend_halt = 1'b0;
			end
		end else if (auto_halt || (s_q.pend_halt && rec_done)) begin
			s_d.mode = CHM_HALT;
			s_d.pend_halt = 1'b0;
		end else if (forced) begin
			s_d.pend_halt = 1'b0;
		end

		// Bus-off state and recovery counting
		case (s_q.bo)
			BO_ON: begin
				if (boe) begin
					s_d.bo = BO_OFF;
					s_d.run = '0;
					s_d.rcnt = '0;
					s_d.supp = 1'b0;
				end
			end
			BO_OFF: begin
				if (rec_done || forced || mode_rst_wr) begin
					s_d.bo = BO_ON;
				end else if (CORE_IN.bit_strobe) begin
					if (!CORE_IN.rx_bit) begin
						s_d.run = '0;
					end else if (s_q.run == RUN_LAST) begin
						s_d.run = '0;
						s_d.rcnt = s_q.rcnt + 7'h01;
					end else begin
						s_d.run = s_q.run + 4'h1;
					end
				end
				if (halt_prog) begin
					s_d.supp = 1'b1;
				end
			end
			default: begin
				s_d.bo = BO_ON;
			end
		endcase

		// Dominant run for lock detection, held once lock is seen
		if (!is_op || (CORE_IN.bit_strobe && CORE_IN.rx_bit)) begin
			s_d.dom = '0;
		end else if (CORE_IN.bit_strobe && s_q.dom != LOCK_LAST + 6'h01) begin
			s_d.dom = s_q.dom + 6'h01;
		end

		// Occurrence counters saturate and clear in channel reset
		if (s_q.mode == CHM_RESET) begin
			s_d.ecnt = '0;
			s_d.scnt = '0;
		end else begin
			if (CORE_IN.err_cnt_match && s_q.ecnt != CNT_MAX) begin
				s_d.ecnt = s_q.ecnt + 8'h01;
			end
			if (CORE_IN.frame_ok && s_q.scnt != CNT_MAX) begin
				s_d.scnt = s_q.scnt + 8'h01;
			end
		end

		// Interrupt requests, a level while an enabled flag stands; the transmit line also follows the core request inputs
		s_d.girq = |(s_q.gflg & s_q.gie);
		s_d.cirq = |(s_q.cflg & s_q.cie);
		s_d.tirq = (s_q.abort_flg & s_q.taie) | CORE_IN.tx_done_req
		         | CORE_IN.cf_tx_req | CORE_IN.hist_req;

		// Read data; unmapped addresses read zero
		s_d.rdat = '0;
		if (acc && !WB_REQ_IN.we) begin
			if (adr == OFS_GLOBAL_CONTROL_REG) begin
				s_d.rdat[GR_BIT] = s_q.glob_rst;
				s_d.rdat[DLCEN_BIT] = s_q.dlc_en;
				s_d.rdat[GIE_LSB +: 4] = s_q.gie;
			end else if (adr == OFS_GFLG) begin
				s_d.rdat[3:0] = s_q.gflg;
			end else if (adr == OFS_CCTLL) begin
				s_d.rdat[MODE_LSB +: 2] = s_q.mode;
				s_d.rdat[CIE_LSB +: 11] = s_q.cie;
				s_d.rdat[TAIE_BIT] = s_q.taie;
			end else if (adr == OFS_CCTLH) begin
				s_d.rdat[POL_LSB +: 2] = s_q.pol;
			end else if (adr == OFS_CFLG) begin
				s_d.rdat[10:0] = s_q.cflg;
				s_d.rdat[DET_LSB +: 6] = s_q.eflg;
			end else if (adr == OFS_CSTS) begin
				s_d.rdat[1:0] = s_q.mode;
				s_d.rdat[2] = busoff;
				s_d.rdat[3] = s_q.pas_l;
				s_d.rdat[4] = s_q.warn_l;
				s_d.rdat[5] = s_q.pend_halt;
				s_d.rdat[ECNT_LSB +: 8] = s_q.ecnt;
				s_d.rdat[SCNT_LSB +: 8] = s_q.scnt;
			end else if (adr == OFS_TXF) begin
				s_d.rdat[0] = s_q.abort_flg;
			end
		end
	end

	// ==========================================================
	// State register; channel and global start in reset mode
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			s_q <= '0;
			s_q.glob_rst <= 1'b1;
			s_q.mode <= CHM_RESET;
			s_q.bo <= BO_ON;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from state bits
	assign WB_ACK_OUT    = s_q.ack;
	assign WB_DAT_OUT    = s_q.rdat;
	assign GERR_IRQ_OUT  = s_q.girq;
	assign CHERR_IRQ_OUT = s_q.cirq;
	assign CHTX_IRQ_OUT  = s_q.tirq;
	assign CH_MODE_OUT   = s_q.mode;
	assign BUSOFF_OUT    = s_q.bo[1]; // One-hot bit of the off state

	// ==========================================================
	// Assertions
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!ARST_N_IN);

	sequence short_frame_s;
		CORE_IN.rx_done && s_q.dlc_en
			&& (CORE_IN.rx_dlc < CORE_IN.rule_min_dlc);
	endsequence

	sequence last_recessive_s;
		busoff && CORE_IN.bit_strobe && CORE_IN.rx_bit
			&& s_q.run == 4'ha && s_q.rcnt == 7'h7f;
	endsequence

	dlc_flag_a: assert property (short_frame_s |=> s_q.gflg[0])
		else $error("DLC error not flagged");
	fifo_lost_a: assert property (
		CORE_IN.fifo_full_store |=> s_q.gflg[1])
		else $error("Message lost not flagged");
	pov_masked_a: assert property (short_frame_s |-> !pov)
		else $error("Overflow raised with DLC error");
	warn_once_a: assert property ($rose(warn_lvl) |=> s_q.cflg[1])
		else $error("Warning event missing");
	boe_entry_a: assert property (
		$rose(CORE_IN.tx_error_counter > 9'h0ff) && !busoff
		|=> busoff && s_q.cflg[3])
		else $error("Bus-off entry missed");
	recovery_a: assert property (
		last_recessive_s ##0 (s_q.pol == 2'h0)
		##0 !s_q.supp ##0 !mode_wr |=> !busoff && s_q.cflg[4])
		else $error("Recovery not completed");
	bor_cause_a: assert property ($rose(s_q.cflg[4])
		|-> $past(busoff))
		else $error("Recovery event without bus-off");
	lock_a: assert property (is_op && CORE_IN.bit_strobe
		&& !CORE_IN.rx_bit && s_q.dom == 6'h1f
		|=> s_q.cflg[6])
		else $error("Bus lock missed");
	defer_halt_a: assert property (
		mode_wr && busoff && s_q.pol == 2'h0 && new_mode == 2'h2
		|=> s_q.mode == $past(s_q.mode) && s_q.pend_halt)
		else $error("Halt not deferred in bus-off");
	write_wins_a: assert property (mode_wr && auto_halt
		|=> s_q.mode == $past(new_mode))
		else $error("Automatic halt beat program write");
	eoco_a: assert property (CORE_IN.err_cnt_match && s_q.ecnt == 8'hff
		|=> s_q.cflg[8])
		else $error("Error counter overflow missed");
	abort_irq_a: assert property (CORE_IN.abort_done && s_q.taie
		|=> ##1 CHTX_IRQ_OUT)
		else $error("Abort not on transmit irq");

endmodule // ceebr_top

`default_nettype wire

// *** test/ceebr_can_model.sv ***
// CAN bus partner model: bit strobes and sampled bus level
`timescale 1ns/10ps
`default_nettype none

module ceebr_can_model (
	input  wire logic clk_in,
	output logic      strobe_out,
	output logic      bit_out
);
	// ==========================================================
	// Bus idles recessive through the pull-up; no strobe between frames
	initial begin
		strobe_out = 1'b0;
		bit_out = 1'b1;
	end

	// Sends n bits of one level; gap idle clocks make a slow bus
	task automatic send(input int n, input logic lvl, input int gap);
		repeat (n) begin
			@(posedge clk_in);
			strobe_out <= 1'b1;
			bit_out <= lvl;
			@(posedge clk_in);
			strobe_out <= 1'b0;
			repeat (gap) @(posedge clk_in);
		end
		bit_out <= 1'b1;
	endtask
endmodule // ceebr_can_model
`default_nettype wire

// *** test/test_ceebr_top.sv ***
// Self-checking bench for the error-event and bus-off block
`timescale 1ns/10ps
`default_nettype none

module test_ceebr_top;
	import ceebr_pkg::*;
	logic          clk, rst_n, ack, gi, ci, ti, bo, strb, rxb;
	logic [1:0]    md;
	logic [31:0]   rd, r;
	ceebr_wb_req_s req;
	ceebr_core_s   base, ev, core, core_in;
	int            n_errors, samples_checked;

	// ==========================================================
	// Clock and wiring; bus level comes from the partner model
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always_comb begin
		core_in = core;
		core_in.bit_strobe = strb;
		core_in.rx_bit = rxb;
	end
	ceebr_top u_dut (.CLK_IN(clk), .ARST_N_IN(rst_n), .WB_REQ_IN(req),
		.WB_ACK_OUT(ack), .WB_DAT_OUT(rd), .CORE_IN(core_in),
		.GERR_IRQ_OUT(gi), .CHERR_IRQ_OUT(ci), .CHTX_IRQ_OUT(ti),
		.CH_MODE_OUT(md), .BUSOFF_OUT(bo));
	ceebr_can_model u_bus (.clk_in(clk), .strobe_out(strb), .bit_out(rxb));

	// ==========================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic end_sim();
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Classic cycle: hold until ack, then release for an idle cycle
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b1, w, a, 4'hf, d};
		// No local limit: only the watchdog ends a wait for ack
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		r = rd;
		req.cyc <= 1'b0;
		req.stb <= 1'b0;
	endtask
	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] m, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(nm, e, r & m);
	endtask
	// One-cycle pulse on top of the standing levels
	task automatic fire(input ceebr_core_s v);
		@(posedge clk);
		core <= v;
		@(posedge clk);
		core <= base;
	endtask
	task automatic clr();
		wb(1'b1, OFS_CFLG, 32'hffffffff);
	endtask
	// Length check wins; overflow only looked at when length passes
	function automatic logic [31:0] gexp(input ceebr_core_s c);
		if (c.rx_dlc < c.rule_min_dlc) return 32'h1;
		return (c.rx_len > c.buf_size) ? 32'h8 : 32'h0;
	endfunction

	// Watchdog sized well above the four bus-off recoveries
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		end_sim();
	end

	// ==========================================================
	// Main sequence
	initial begin
		rst_n = 1'b0;
		req = '0;
		base = '0;
		core = '0;
		n_errors = 0;
		samples_checked = 0;
		void'($urandom(2));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		// Enables written while in global reset, then kept on leaving it
		wb(1'b1, OFS_GLOBAL_CONTROL_REG, 32'hf03);
		wb(1'b1, OFS_GLOBAL_CONTROL_REG, 32'hf02);
		// Enable byte written outside global reset must not land
		wb(1'b1, OFS_GLOBAL_CONTROL_REG, 32'h002);
		rdc("global_control_reg", OFS_GLOBAL_CONTROL_REG, 32'hfff, 32'hf02);
		// First frame is the corner: short DLC and oversize payload
		base.rx_dlc = 4'h2;
		base.rule_min_dlc = 4'h5;
		base.rx_len = 7'h40;
		base.buf_size = 7'h08;
		for (int i = 0; i < 10; i++) begin
			if (i > 0) begin
				base.rx_dlc = 4'($urandom);
				base.rule_min_dlc = 4'($urandom);
				base.rx_len = 7'($urandom);
				base.buf_size = 7'($urandom);
			end
			ev = base;
			ev.rx_done = 1'b1;
			fire(ev);
			rdc("gflg", OFS_GFLG, 32'hf, gexp(ev));
			chk("girq", {31'h0, gexp(ev) != 0}, {31'h0, gi});
			wb(1'b1, OFS_GFLG, 32'hf);
		end
		ev = base;
		ev.fifo_full_store = 1'b1;
		ev.hist_full_store = 1'b1;
		fire(ev);
		rdc("gflg", OFS_GFLG, 32'hf, 32'h6);
		wb(1'b1, OFS_GFLG, 32'hf);
		@(posedge clk);
		chk("girq", 32'h0, {31'h0, gi});
		// Channel to operation with every error source enabled
		wb(1'b1, OFS_CCTLL, 32'hfff00);
		for (int i = 0; i < 6; i++) begin
			ev = base;
			ev.err_detail = 6'(1 << i);
			fire(ev);
			rdc("berr", OFS_CFLG, '1, (32'h10000 << i) | 32'h1);
			chk("cirq", 32'h1, {31'h0, ci});
			clr();
		end
		ev = base;
		ev.overload = 1'b1;
		ev.arb_lost = 1'b1;
		fire(ev);
		rdc("ovl_arb", OFS_CFLG, '1, 32'ha0);
		clr();
		u_bus.send(31, 1'b0, 0);
		rdc("lock", OFS_CFLG, 32'h40, 32'h0);
		u_bus.send(1, 1'b0, 2);
		rdc("lock", OFS_CFLG, 32'h40, 32'h40);
		clr();
		// Counters reach FF after 255 events; the next one overflows
		ev = base;
		ev.err_cnt_match = 1'b1;
		ev.frame_ok = 1'b1;
		repeat (255) fire(ev);
		rdc("cnt_ov", OFS_CFLG, 32'h300, 32'h0);
		fire(ev);
		rdc("cnt_ov", OFS_CFLG, 32'h300, 32'h300);
		clr();
		// Delay at the limit passes, one clock more violates
		base.dbt_clks = 8'($urandom_range(40, 2));
		ev = base;
		ev.tdc_valid = 1'b1;
		ev.tdc_meas = 8'(6 * base.dbt_clks - 2);
		fire(ev);
		rdc("tdcv", OFS_CFLG, 32'h400, 32'h0);
		ev.tdc_meas = ev.tdc_meas + 8'h1;
		fire(ev);
		rdc("tdcv", OFS_CFLG, 32'h400, 32'h400);
		clr();
		ev = base;
		ev.abort_done = 1'b1;
		fire(ev);
		rdc("abort", OFS_TXF, 32'h1, 32'h1);
		chk("txirq", 32'h1, {31'h0, ti});
		wb(1'b1, OFS_TXF, 32'h1);
		base.cf_tx_req = 1'b1;
		fire(base);
		// The level is registered, so look one edge after it is sampled
		@(posedge clk);
		chk("txirq", 32'h1, {31'h0, ti});
		base.cf_tx_req = 1'b0;
		// Thresholds: each level event only on its first crossing
		base.rec = 8'd96;
		fire(base);
		rdc("warn", OFS_CFLG, 32'h1e, 32'h2);
		clr();
		base.tx_error_counter = 9'd128;
		fire(base);
		rdc("pass", OFS_CFLG, 32'h1e, 32'h4);
		clr();
		base.rec = 8'd0;
		base.tx_error_counter = 9'd200;
		fire(base);
		rdc("again", OFS_CFLG, 32'h1e, 32'h0);
		base.tx_error_counter = 9'd256;
		fire(base);
		rdc("boe", OFS_CFLG, 32'h1e, 32'h8);
		chk("busoff", 32'h1, {31'h0, bo});
		// Halt asked during bus-off waits for the recovery to end
		wb(1'b1, OFS_CCTLL, 32'hfff02);
		chk("mode", 32'h0, {30'h0, md});
		u_bus.send(1407, 1'b1, 1);
		chk("busoff", 32'h1, {31'h0, bo});
		u_bus.send(1, 1'b1, 0);
		repeat (3) @(posedge clk);
		chk("busoff", 32'h0, {31'h0, bo});
		rdc("bor", OFS_CFLG, 32'h10, 32'h10);
		chk("mode", 32'h2, {30'h0, md});
		// Halt at entry: no recovery event afterwards
		clr();
		wb(1'b1, OFS_CCTLL, 32'hfff00);
		wb(1'b1, OFS_CCTLH, 32'h1);
		base.tx_error_counter = 9'd0;
		fire(base);
		base.tx_error_counter = 9'd300;
		fire(base);
		@(posedge clk);
		chk("mode", 32'h2, {30'h0, md});
		rdc("boe", OFS_CFLG, 32'h8, 32'h8);
		u_bus.send(1408, 1'b1, 1);
		repeat (3) @(posedge clk);
		rdc("bor", OFS_CFLG, 32'h10, 32'h0);
		// Policy 3: program halt acts at once and silences recovery
		clr();
		wb(1'b1, OFS_CCTLL, 32'hfff00);
		wb(1'b1, OFS_CCTLH, 32'h3);
		base.tx_error_counter = 9'd0;
		fire(base);
		base.tx_error_counter = 9'd300;
		fire(base);
		wb(1'b1, OFS_CCTLL, 32'hfff02);
		chk("mode", 32'h2, {30'h0, md});
		u_bus.send(1408, 1'b1, 0);
		repeat (3) @(posedge clk);
		chk("busoff", 32'h0, {31'h0, bo});
		rdc("bor", OFS_CFLG, 32'h18, 32'h8);
		// Forced exit, then a reset-mode write, end bus-off silently
		clr();
		wb(1'b1, OFS_CCTLH, 32'h0);
		wb(1'b1, OFS_CCTLL, 32'hfff00);
		for (int i = 0; i < 2; i++) begin
			base.tx_error_counter = 9'd0;
			fire(base);
			base.tx_error_counter = 9'(257 + $urandom_range(254));
			fire(base);
			@(posedge clk);
			chk("busoff", 32'h1, {31'h0, bo});
			wb(1'b1, OFS_CCTLL, (i == 0) ? 32'hfff04 : 32'hfff01);
			chk("busoff", 32'h0, {31'h0, bo});
		end
		rdc("bor", OFS_CFLG, 32'h18, 32'h8);
		// Policy 2: halt taken automatically when recovery ends
		wb(1'b1, OFS_CCTLH, 32'h2);
		wb(1'b1, OFS_CCTLL, 32'hfff00);
		base.tx_error_counter = 9'd0;
		fire(base);
		base.tx_error_counter = 9'd300;
		fire(base);
		u_bus.send(1408, 1'b1, 0);
		repeat (3) @(posedge clk);
		chk("mode", 32'h2, {30'h0, md});
		rdc("bor", OFS_CFLG, 32'h10, 32'h10);
		end_sim();
	end
endmodule // test_ceebr_top
`default_nettype wire
